// *** rtl/capture_compare_pkg.sv ***
// Purpose: Shared constants for the capture/compare mode control block.
// Assumes: APB register map with one aligned 32-bit word per register.
// Notes:   Offsets are byte addresses; field positions index the mode, status and mask registers.
package capture_compare_pkg;

    // Register byte offsets.
    localparam logic [7:0] MODE_OFFSET    = 8'h00;
    localparam logic [7:0] CMP_OFFSET     = 8'h04;
    localparam logic [7:0] STATUS_OFFSET  = 8'h08;
    localparam logic [7:0] MASK_OFFSET    = 8'h0C;

    // Mode register layout.
    localparam int unsigned MODE_W        = 8;
    localparam int unsigned WIDE_BIT      = 7;
    localparam int unsigned FALL_CAP_BIT  = 4;
    localparam int unsigned MATCH_BIT     = 3;
    localparam int unsigned TOGGLE_BIT    = 2;
    localparam int unsigned PWM_BIT       = 1;
    localparam int unsigned IRQ_EN_BIT    = 0;
    localparam logic [7:0]  MODE_USED     = 8'h9F;

    // Status and mask layout.
    localparam int unsigned FLAG_BIT      = 0;

    // Reset values.
    localparam logic [7:0]  MODE_RESET    = 8'h00;
    localparam logic [15:0] CMP_RESET     = 16'h0000;
    localparam logic        PIN_RESET     = 1'b0;

    // Widths of the narrow pulse-width form, of the full counter and of the APB address and data.
    localparam int unsigned NARROW_W      = 8;
    localparam int unsigned CNT_W_DEFAULT = 16;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;

    // Output pin operating modes, decoded from the mode bits.
    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_TOGGLE,
        OUT_PWM,
        OUT_FREQ
    } out_mode_t;

endpackage

// *** rtl/capture_compare_mode_control.sv ***
// Purpose: One capture/compare module of a counter array, with its mode bits,
//          compare value, flag and pin logic, reached over APB.
// Assumes: The shared counter lives outside; COUNT_TICK_I pulses in the cycle
//          in which COUNT_I holds a new value. The pin input is synchronous.
// Notes:   Zero wait state APB slave; read data is latched in the setup cycle.
`timescale 1ns/100ps

// Summary of operation
// R1: Falling pin edges capture only while the falling-capture enable bit is set.
// R2: With match enabled, counter equal to compare value sets the flag.
// R3: With toggle enabled, each counter match inverts the module output pin.
// R4: Toggle and pulse-width enables together select frequency output mode.
// R5: Pulse-width enable drives a modulated waveform; cleared, no waveform except the toggle on each match when toggle is enabled.
// R6: Wide-pulse select picks a 16-bit form, otherwise the 8-bit form.
// R7: Flag interrupt enable cleared means no interrupt request from the flag.
// R8: Flag interrupt enable set raises a request whenever the flag is set.
// R9: A capture copies the counter value and sets the flag in one cycle.
module capture_compare_mode_control #(
    parameter int unsigned CNT_W = capture_compare_pkg::CNT_W_DEFAULT
) (
    // Clock and reset.
    input  wire logic                                     CLK_I,
    input  wire logic                                     RSTN_I,
    // APB slave.
    input  wire logic                                     PSEL_I,
    input  wire logic                                     PENABLE_I,
    input  wire logic                                     PWRITE_I,
    input  wire logic [capture_compare_pkg::ADDR_W-1:0]   PADDR_I,
    input  wire logic [capture_compare_pkg::DATA_W-1:0]   PWDATA_I,
    input  wire logic [3:0]                               PSTRB_I,
    output logic      [capture_compare_pkg::DATA_W-1:0]   PRDATA_O,
    output logic                                          PREADY_O,
    output logic                                          PSLVERR_O,
    // Shared counter.
    input  wire logic [CNT_W-1:0]                         COUNT_I,
    input  wire logic                                     COUNT_TICK_I,
    // Module pin, split into input, output and output enable.
    input  wire logic                                     PIN_I,
    output logic                                          PIN_O,
    output logic                                          PIN_OE_O,
    // Interrupt request.
    output logic                                          IRQ_O
);

    localparam int unsigned NW = capture_compare_pkg::NARROW_W;

    // The narrow form and frequency mode split the compare value in two bytes,
    // and the read path zero-extends it into one bus word, so both bounds matter.
    // Refusing the width at elaboration beats a silently truncated compare value.
    if (CNT_W < 2 * NW || CNT_W > capture_compare_pkg::DATA_W) begin : g_width_check
        $error("CNT_W must lie between twice the narrow width and the data width");
    end

    logic [7:0]       mode_reg;
    logic [CNT_W-1:0] cmp_reg;
    logic             flag_reg;
    logic             pin_reg;
    logic             pin_q_reg;
    logic [31:0]      rdata_reg;
    logic             err_reg;
    logic [CNT_W-1:0] cmp_next;
    logic             pin_next;

    // Bus decode.
    wire setup_ph  = PSEL_I && !PENABLE_I;
    wire access_ph = PSEL_I && PENABLE_I;
    wire aligned   = (PADDR_I[1:0] == 2'b00);
    wire sel_mode  = aligned && (PADDR_I == capture_compare_pkg::MODE_OFFSET);
    wire sel_cmp   = aligned && (PADDR_I == capture_compare_pkg::CMP_OFFSET);
    wire sel_stat  = aligned && (PADDR_I == capture_compare_pkg::STATUS_OFFSET);
    wire sel_mask  = aligned && (PADDR_I == capture_compare_pkg::MASK_OFFSET);
    wire mapped    = sel_mode || sel_cmp || sel_stat || sel_mask;
    wire wr_acc    = access_ph && PWRITE_I;
    wire wr_mode   = wr_acc && sel_mode && PSTRB_I[0];
    wire wr_mask   = wr_acc && sel_mask && PSTRB_I[0];
    wire wr_cmp_lo = wr_acc && sel_cmp && PSTRB_I[0];
    wire wr_cmp_hi = wr_acc && sel_cmp && PSTRB_I[1];
    wire wr_clear  = wr_acc && sel_stat && PSTRB_I[0]
                     && PWDATA_I[capture_compare_pkg::FLAG_BIT];

    // Mode bit fields.
    wire wide_sel  = mode_reg[capture_compare_pkg::WIDE_BIT];
    wire cap_en    = mode_reg[capture_compare_pkg::FALL_CAP_BIT];
    wire match_en  = mode_reg[capture_compare_pkg::MATCH_BIT];
    wire toggle_en = mode_reg[capture_compare_pkg::TOGGLE_BIT];
    wire pwm_en    = mode_reg[capture_compare_pkg::PWM_BIT];
    wire irq_en    = mode_reg[capture_compare_pkg::IRQ_EN_BIT];

    // Operating mode of the pin; both enables together mean frequency output.
    capture_compare_pkg::out_mode_t out_mode;
    assign out_mode = (toggle_en && pwm_en) ? capture_compare_pkg::OUT_FREQ   : // R4
                      pwm_en                ? capture_compare_pkg::OUT_PWM    :
                      toggle_en             ? capture_compare_pkg::OUT_TOGGLE :
                                              capture_compare_pkg::OUT_IDLE;

    // Events from the counter and from the pin.
    wire fall_edge = pin_q_reg && !PIN_I;
    wire capture   = cap_en && fall_edge;                               // R1
    wire full_hit  = COUNT_TICK_I && (COUNT_I == cmp_reg);
    wire low_hit   = COUNT_TICK_I && (COUNT_I[NW-1:0] == cmp_reg[NW-1:0]);
    wire flag_set  = capture || (match_en && full_hit);                 // R2 R9

    // Pulse-width comparisons: output high while the counter is below compare.
    wire pwm_narrow = (COUNT_I[NW-1:0] < cmp_reg[NW-1:0]);
    wire pwm_wide   = (COUNT_I < cmp_reg);

    // Next compare value: capture wins over a software write in the same cycle,
    // since losing a hardware timestamp cannot be repaired afterwards.
    always_comb begin
        cmp_next = cmp_reg;
        if (wr_cmp_lo) begin
            cmp_next[NW-1:0] = PWDATA_I[NW-1:0];
        end
        if (wr_cmp_hi) begin
            cmp_next[CNT_W-1:NW] = PWDATA_I[CNT_W-1:NW];
        end
        if (capture) begin
            cmp_next = COUNT_I;                                         // R9
        end else if (out_mode == capture_compare_pkg::OUT_FREQ && low_hit) begin
            // The high byte sets the half period of the square wave.
            cmp_next[NW-1:0] = cmp_reg[NW-1:0] + cmp_reg[2*NW-1:NW];     // R4
        end
    end

    // Next pin level for each operating mode.
    always_comb begin
        pin_next = pin_reg;
        unique case (out_mode)
            capture_compare_pkg::OUT_TOGGLE: begin
                if (full_hit) begin
                    pin_next = !pin_reg;                                // R3
                end
            end
            capture_compare_pkg::OUT_PWM: begin
                pin_next = wide_sel ? pwm_wide : pwm_narrow;            // R5 R6
            end
            capture_compare_pkg::OUT_FREQ: begin
                if (low_hit) begin
                    pin_next = !pin_reg;                                // R4
                end
            end
            capture_compare_pkg::OUT_IDLE: begin
                pin_next = pin_reg;
            end
        endcase
    end

    // Mode register; the mask register aliases the interrupt enable bit.
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            mode_reg <= capture_compare_pkg::MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= PWDATA_I[7:0] & capture_compare_pkg::MODE_USED;
        end else if (wr_mask) begin
            mode_reg[capture_compare_pkg::IRQ_EN_BIT] <=
                PWDATA_I[capture_compare_pkg::FLAG_BIT];
        end
    end

    // Compare value, pin level and pin history.
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            cmp_reg   <= CNT_W'(capture_compare_pkg::CMP_RESET);
            pin_reg   <= capture_compare_pkg::PIN_RESET;
            pin_q_reg <= 1'b1;
        end else begin
            cmp_reg   <= cmp_next;
            pin_reg   <= pin_next;
            pin_q_reg <= PIN_I;
        end
    end

    // Sticky flag: a set in the clearing cycle wins over the clear.
    // A clear thus never hides an event that software has not yet seen.
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            flag_reg <= 1'b0;
        end else if (flag_set) begin
            flag_reg <= 1'b1;                                           // R2 R9
        end else if (wr_clear) begin
            flag_reg <= 1'b0;
        end
    end

    // Read data and error are latched in the setup cycle for zero wait states.
    // A read racing a flag set returns the setup-cycle value; the next read shows it.
    wire [31:0] rd_mux =
        sel_mode ? {24'h000000, mode_reg} :
        sel_cmp  ? {{(32 - CNT_W){1'b0}}, cmp_reg} :
        sel_stat ? {31'h00000000, flag_reg} :
        sel_mask ? {31'h00000000, irq_en} : 32'h00000000;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            rdata_reg <= 32'h00000000;
            err_reg   <= 1'b0;
        end else if (setup_ph) begin
            rdata_reg <= PWRITE_I ? 32'h00000000 : rd_mux;
            err_reg   <= !mapped;
        end
    end

    // Outputs.
    assign PRDATA_O  = rdata_reg;
    assign PREADY_O  = access_ph;
    assign PSLVERR_O = access_ph && err_reg;
    assign PIN_O     = pin_reg;
    assign PIN_OE_O  = (out_mode != capture_compare_pkg::OUT_IDLE);     // R5
    assign IRQ_O     = flag_reg && irq_en;                              // R7 R8

    // Checks.
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence fall_armed_s;
        cap_en && fall_edge;
    endsequence

    sequence copy_done_s(logic [CNT_W-1:0] val);
        (cmp_reg == val) && flag_reg;
    endsequence

    sequence freq_step_s;
        (out_mode == capture_compare_pkg::OUT_FREQ) && low_hit;
    endsequence

    capture_copy_a: assert property (                                   // R9
        fall_armed_s |=> copy_done_s($past(COUNT_I)))
        else $error("capture did not copy the counter and set the flag");

    no_capture_a: assert property (                                     // R1
        (!cap_en && !wr_cmp_lo && !wr_cmp_hi
         && out_mode != capture_compare_pkg::OUT_FREQ) |=> $stable(cmp_reg))
        else $error("compare value changed without an enabled capture");

    match_flag_a: assert property (                                     // R2
        (match_en && full_hit) |=> flag_reg)
        else $error("enabled match did not set the flag");

    toggle_pin_a: assert property (                                     // R3
        (out_mode == capture_compare_pkg::OUT_TOGGLE && full_hit)
        |=> (PIN_O != $past(PIN_O)) && PIN_OE_O)
        else $error("match did not invert the pin");

    freq_step_a: assert property (                                      // R4
        (freq_step_s and !capture) |=> (PIN_O != $past(PIN_O))
        && (cmp_reg[NW-1:0] == NW'($past(cmp_reg[NW-1:0]) + $past(cmp_reg[2*NW-1:NW]))))
        else $error("frequency mode step wrong");

    pwm_narrow_a: assert property (                                     // R6
        (out_mode == capture_compare_pkg::OUT_PWM && !wide_sel)
        |=> PIN_O == ($past(COUNT_I[NW-1:0]) < $past(cmp_reg[NW-1:0])))
        else $error("narrow pulse width output wrong");

    pwm_wide_a: assert property (                                       // R6
        (out_mode == capture_compare_pkg::OUT_PWM && wide_sel)
        |=> PIN_O == ($past(COUNT_I) < $past(cmp_reg)))
        else $error("wide pulse width output wrong");

    pin_quiet_a: assert property (                                      // R5
        (out_mode == capture_compare_pkg::OUT_IDLE) |=> !PIN_OE_O || $stable(PIN_O))
        else $error("pin waveform while no output mode is enabled");

    irq_masked_a: assert property (!irq_en |-> !IRQ_O)                  // R7
        else $error("interrupt raised while masked");

    irq_raise_a: assert property (                                      // R8
        (irq_en && flag_set) |=> IRQ_O)
        else $error("flag set did not raise the interrupt");

    set_wins_a: assert property (                                       // R2
        (flag_set && wr_clear) |=> flag_reg)
        else $error("clear overrode a flag set in the same cycle");

    // Quiet cycles: the pin only moves on the event of its mode, and the flag
    // only rises for an enabled event, so stray toggles or sets are caught here.
    sequence pin_hold_s;
        $stable(PIN_O);
    endsequence

    toggle_hold_a: assert property (                                    // R3
        (out_mode == capture_compare_pkg::OUT_TOGGLE && !full_hit) |=> pin_hold_s)
        else $error("pin moved in toggle mode without a match");

    freq_hold_a: assert property (                                      // R4
        (out_mode == capture_compare_pkg::OUT_FREQ && !low_hit) |=> pin_hold_s)
        else $error("pin moved in frequency mode without a low byte match");

    fall_refused_a: assert property (                                   // R1
        (fall_edge && !cap_en && !(match_en && full_hit) && !flag_reg) |=> !flag_reg)
        else $error("disabled falling edge set the flag");

    match_refused_a: assert property (                                  // R2
        (full_hit && !match_en && !capture && !flag_reg) |=> !flag_reg)
        else $error("disabled match set the flag");

    pwm_drive_a: assert property (pwm_en |-> PIN_OE_O)                  // R5
        else $error("pulse width enabled but pin not driven");

    irq_clear_a: assert property (                                      // R8
        (wr_clear && !flag_set) |=> !IRQ_O)
        else $error("interrupt request stayed after the flag was cleared");

endmodule // capture_compare_mode_control

// *** tb/pin_partner.sv ***
// Purpose: Board side of the module pin, seen by the capture/compare block.
// Assumes: The pin has a pull-up, and the block drives it while its enable is high.
// Notes:   The bench steers the model through drive_en_i and level_i.
`timescale 1ns/100ps
module pin_partner (
    // Design side of the pin.
    input  wire logic pin_o_i,
    input  wire logic pin_oe_i,
    // Steering from the bench.
    input  wire logic drive_en_i,
    input  wire logic level_i,
    // Resolved wire level.
    output logic      wire_o
);
    // A released pin rises through the pull-up, so no stale level lingers.
    assign wire_o = pin_oe_i ? pin_o_i : (drive_en_i ? level_i : 1'b1);
endmodule // pin_partner

// *** tb/test_capture_compare_mode_control.sv ***
// Purpose: Self-checking bench for the capture/compare mode control block.
// Assumes: Zero wait state APB slave; one-cycle pin and flag response.
// Notes:   Each scenario is a task that drives the block and judges the result.
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_capture_compare_mode_control;
    logic        clk, rstn, psel, penable, pwrite, tick, lvl, drv;
    logic        pready, pslverr, pin_o, pin_oe, irq, pin_w;
    logic [7:0]  paddr;
    logic [3:0]  pstrb;
    logic [15:0] count;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    int          n_mismatch, total_checks;

    capture_compare_mode_control dut (.CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .COUNT_I(count), .COUNT_TICK_I(tick), .PIN_I(pin_w), .PIN_O(pin_o),
        .PIN_OE_O(pin_oe), .IRQ_O(irq));
    pin_partner partner (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .drive_en_i(drv),
        .level_i(lvl), .wire_o(pin_w));

    // Free running 20 MHz clock.
    always #25 clk = ~clk;

    // Ends the run with the verdict.
    task automatic complete_run();
        if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // One APB transfer; the request is held until pready is seen high. An idle
    // edge follows, so the write is visible on return and no signal is driven
    // twice in one time step by back to back calls.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask

    // Presents a counter value with a tick, then lets the result land.
    task automatic cnt(input logic [15:0] v);
        count <= v;
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Drives a falling edge on the pin from the board side.
    task automatic fall();
        lvl <= 1'b1;
        repeat (3) @(posedge clk);
        lvl <= 1'b0;
        repeat (3) @(posedge clk);
        lvl <= 1'b1;
        @(posedge clk);
    endtask

    // Reset held for eight cycles, then outputs and registers are checked.
    task automatic t_reset();
        rstn <= 1'b0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        `CHK({pin_o, pin_oe, irq}, 3'b000)
        rchk(capture_compare_pkg::MODE_OFFSET, 32'h0);
        rchk(capture_compare_pkg::STATUS_OFFSET, 32'h0);
    endtask

    // Reserved mode bits read zero; an unmapped address is refused; a byte
    // strobe limits a write to its own byte.
    task automatic t_regs();
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'hFF);
        rchk(capture_compare_pkg::MODE_OFFSET, 32'h9F);
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h0);
        rchk(8'h10, 32'h0);
        `CHK(e, 1'b1)
        // All modes at once drove the pin low and captured a zero; clear the flag.
        apb(1'b1, capture_compare_pkg::STATUS_OFFSET, 32'h1);
        pstrb <= 4'h1;
        apb(1'b1, capture_compare_pkg::CMP_OFFSET, 32'hABCD);
        pstrb <= 4'hF;
        rchk(capture_compare_pkg::CMP_OFFSET, 32'h00CD);
    endtask

    // A fall is ignored while disabled, then captured with the flag and irq.
    task automatic t_capture();
        count <= 16'h1234;
        fall();
        rchk(capture_compare_pkg::STATUS_OFFSET, 32'h0);
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h11);
        fall();
        `CHK(irq, 1'b1)
        rchk(capture_compare_pkg::CMP_OFFSET, 32'h1234);
        rchk(capture_compare_pkg::STATUS_OFFSET, 32'h1);
        apb(1'b1, capture_compare_pkg::STATUS_OFFSET, 32'h1);
        `CHK(irq, 1'b0)
    endtask

    // Match sets the flag only on equality; irq stays masked until enabled.
    task automatic t_match();
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h08);
        apb(1'b1, capture_compare_pkg::CMP_OFFSET, 32'h0005);
        cnt(16'h0004);
        rchk(capture_compare_pkg::STATUS_OFFSET, 32'h0);
        cnt(16'h0005);
        rchk(capture_compare_pkg::STATUS_OFFSET, 32'h1);
        `CHK(irq, 1'b0)
        apb(1'b1, capture_compare_pkg::MASK_OFFSET, 32'h1);
        `CHK(irq, 1'b1)
        apb(1'b1, capture_compare_pkg::STATUS_OFFSET, 32'h1);
    endtask

    // Each match inverts the pin; a non-matching value leaves it alone.
    task automatic t_toggle();
        drv <= 1'b0;
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h04);
        apb(1'b1, capture_compare_pkg::CMP_OFFSET, 32'h0020);
        cnt(16'h0020);
        `CHK({pin_oe, pin_o}, 2'b11)
        cnt(16'h0021);
        `CHK(pin_o, 1'b1)
        cnt(16'h0020);
        `CHK(pin_o, 1'b0)
    endtask

    // Pulse width in the narrow and wide forms tell apart by the high byte.
    task automatic t_pwm();
        apb(1'b1, capture_compare_pkg::CMP_OFFSET, 32'h0180);
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h02);
        cnt(16'h0250);
        `CHK(pin_o, 1'b1)
        cnt(16'h0090);
        `CHK(pin_o, 1'b0)
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h82);
        cnt(16'h0090);
        `CHK(pin_o, 1'b1)
        cnt(16'h0250);
        `CHK(pin_o, 1'b0)
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h00);
        cnt(16'h0000);
        `CHK(pin_oe, 1'b0)
    endtask

    // Frequency output toggles on low-byte match and advances the compare.
    task automatic t_freq();
        apb(1'b1, capture_compare_pkg::CMP_OFFSET, 32'h0302);
        apb(1'b1, capture_compare_pkg::MODE_OFFSET, 32'h06);
        cnt(16'h0102);
        `CHK(pin_o, 1'b1)
        rchk(capture_compare_pkg::CMP_OFFSET, 32'h0305);
        cnt(16'h0105);
        `CHK(pin_o, 1'b0)
    endtask

    // Main sequence; the freq test starts from a fresh reset for a known pin.
    initial begin
        {clk, rstn, psel, penable, pwrite, tick} = 6'b0;
        pstrb = 4'hF;
        {paddr, pwdata, count, lvl, drv} = {8'h0, 32'h0, 16'h0, 2'b11};
        t_reset();
        t_regs();
        t_capture();
        t_match();
        t_toggle();
        t_pwm();
        t_reset();
        t_freq();
        complete_run();
    end

    // Cuts a hang short well beyond the expected run of under two hundred cycles.
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule // test_capture_compare_mode_control
